//--- rtl/ibk_bank.sv
// interrupt flag, enable and priority register bank with avalon slave
//
// Design decision made here: the Avalon-MM slave port.
`default_nettype none
//
// Contract
// - flag bit reads 1 once its source requested; read/write, resets 0
// - enable bit 1 lets its source through, 0 blocks; read/write, resets 0
// - base plus 4, 8, 12 clear, set, invert the written mask bits
// - status, event status and event mask registers have no clear, set or invert aliases
// - flag bits 28 to 26 shared by serial1, spi3 and twowire3 sources
module ibk_bank #(
  parameter logic [2:0] DEF_LVL = 3'h1
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire ibk_pkg::ibk_av_req_t    av_req,
  output var  ibk_pkg::ibk_av_rsp_t    av_rsp,
  input  wire logic [95:0]             irq_src,
  input  wire logic [2:0]              serial1_src,
  input  wire logic [2:0]              spi3_src,
  input  wire logic [2:0]              twowire3_src,
  output logic                         cpu_req,
  output logic [2:0]                   cpu_level,
  output logic [5:0]                   cpu_vector,
  output logic                         irq
);
  import ibk_pkg::*;

  // ******************************************
  // bus decode
  // ******************************************
  logic [31:0]      regs_ff [IBK_NRW];
  logic [31:0]      nxt_regs [IBK_NRW];
  logic [IBK_NRW-1:0] rw_hit;
  logic             ack_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       evst_ff;
  logic [1:0]       evmk_ff;
  logic [1:0]       nxt_evst;
  logic [95:0]      pend_ff;
  logic [31:0]      stat_ff;
  logic             cpu_req_ff;
  logic [6:0]       best_idx_ff;
  wire              req_w   = av_req.read | av_req.write;
  wire              first_w = req_w & ~ack_ff;
  wire              wr_go   = av_req.write & ack_ff;
  wire              go_w    = req_w & ack_ff;
  wire [1:0]        op_w    = av_req.address[3:2];
  wire              st_hit  = av_req.address[15:2] == IBK_OFF_STAT[15:2];
  wire              evs_hit = av_req.address[15:2] == IBK_OFF_EVST[15:2];
  wire              evm_hit = av_req.address[15:2] == IBK_OFF_EVMK[15:2];
  wire              mapped  = (|rw_hit) | st_hit | evs_hit | evm_hit;
  wire [31:0]       be_mask = {{8{av_req.byteenable[3]}},
                               {8{av_req.byteenable[2]}},
                               {8{av_req.byteenable[1]}},
                               {8{av_req.byteenable[0]}}};
  wire [31:0]       wmask   = av_req.writedata & be_mask;

  genvar g;
  generate
    for (g = 0; g < IBK_NRW; g++)
    begin : g_hit
      // whole 16-byte block decodes: base and its three aliases
      assign rw_hit[g] = av_req.address[15:4] == IBK_RW_OFF[g][15:4];
    end
  endgenerate

  function automatic logic [31:0] ibk_upd(
    input logic [31:0] old,
    input logic [1:0]  op,
    input logic [31:0] wd,
    input logic [31:0] bm
  );
    logic [31:0] m;
    m = wd & bm;
    unique case (op)
      IBK_OP_BASE: ibk_upd = (old & ~bm) | m;
      IBK_OP_CLR:  ibk_upd = old & ~m;
      IBK_OP_SET:  ibk_upd = old | m;
      IBK_OP_INV:  ibk_upd = old ^ m;
    endcase
  endfunction : ibk_upd

  // ******************************************
  // sources and pending requests
  // ******************************************
  wire [2:0]  share_w = serial1_src | spi3_src | twowire3_src;
  wire [95:0] src_all = irq_src |
                        (96'(share_w) << IBK_SHARE_LSB);
  wire [95:0] flags_w = {regs_ff[IBK_SL_FLG0+2], regs_ff[IBK_SL_FLG0+1],
                         regs_ff[IBK_SL_FLG0]};
  wire [95:0] ena_w   = {regs_ff[IBK_SL_ENA0+2], regs_ff[IBK_SL_ENA0+1],
                         regs_ff[IBK_SL_ENA0]};
  wire [95:0] pend_w  = flags_w & ena_w;

  always_comb
  begin
    for (int i = 0; i < IBK_NRW; i++)
    begin
      nxt_regs[i] = regs_ff[i];
      if (wr_go && rw_hit[i])
        nxt_regs[i] = ibk_upd(regs_ff[i], op_w, av_req.writedata, be_mask);
    end
    // a source event in the same cycle as a clear still lands
    for (int k = 0; k < 3; k++)
      nxt_regs[IBK_SL_FLG0+k] = nxt_regs[IBK_SL_FLG0+k] |
                                src_all[32*k +: 32];
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < IBK_NRW; i++)
      regs_ff[i] <= rst ? IBK_RST : nxt_regs[i];
  end

  // ******************************************
  // ranking: level, then subpriority, then lowest source number
  // ******************************************
  logic [2:0] best_lvl;
  logic [1:0] best_sub;
  logic [6:0] best_idx;
  logic       found;
  logic [2:0] lvl;
  logic [1:0] sub;
  always_comb
  begin
    best_lvl = 3'h0;
    best_sub = 2'h0;
    best_idx = 7'h00;
    found    = 1'b0;
    lvl      = 3'h0;
    sub      = 2'h0;
    for (int s = 0; s < IBK_NSRC; s++)
    begin
      // only four sources have programmable priority here
      if (s < IBK_PRI_SLOTS)
      begin
        lvl = regs_ff[IBK_SL_PRI0][s*IBK_PRI_STRIDE+IBK_PRI_LVL_LSB +: 3];
        sub = regs_ff[IBK_SL_PRI0][s*IBK_PRI_STRIDE+IBK_PRI_SUB_LSB +: 2];
      end
      else
      begin
        lvl = DEF_LVL;
        sub = 2'h0;
      end
      if (pend_w[s] && (!found || lvl > best_lvl ||
          (lvl == best_lvl && sub > best_sub)))
      begin
        found    = 1'b1;
        best_lvl = lvl;
        best_sub = sub;
        best_idx = 7'(s);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cpu_req_ff  <= 1'b0;
      stat_ff     <= IBK_RST;
      best_idx_ff <= 7'h00;
      pend_ff     <= '0;
    end
    else
    begin
      cpu_req_ff  <= found;
      best_idx_ff <= best_idx;
      pend_ff     <= pend_w;
      stat_ff     <= (32'(best_lvl) << IBK_STAT_LVL_LSB) |
                     (32'(best_idx[5:0]) << IBK_STAT_VEC_LSB);
    end
  end

  assign cpu_req    = cpu_req_ff;
  assign cpu_level  = stat_ff[IBK_STAT_LVL_LSB +: 3];
  assign cpu_vector = stat_ff[IBK_STAT_VEC_LSB +: 6];

  // ******************************************
  // event status, mask and interrupt line
  // ******************************************
  wire [1:0] ev_set = {go_w & ~mapped, |(pend_w & ~pend_ff)};
  always_comb
  begin
    nxt_evst = evst_ff;
    if (wr_go && evs_hit)
      nxt_evst = evst_ff & ~wmask[1:0];
    // set wins over the write-one clear
    nxt_evst = nxt_evst | ev_set;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      evst_ff <= 2'h0;
      evmk_ff <= 2'h0;
    end
    else
    begin
      evst_ff <= nxt_evst;
      if (wr_go && evm_hit)
        evmk_ff <= (evmk_ff & ~be_mask[1:0]) | wmask[1:0];
    end
  end

  assign irq = |(evst_ff & evmk_ff);

  // ******************************************
  // read path: one wait state, data captured on the first cycle
  // ******************************************
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < IBK_NRW; i++)
      if (rw_hit[i])
        rd_mux = regs_ff[i]; // aliases read as the base
    if (st_hit)
      rd_mux = stat_ff;
    if (evs_hit)
      rd_mux = 32'(evst_ff);
    if (evm_hit)
      rd_mux = 32'(evmk_ff);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= first_w;
      if (first_w && av_req.read)
        rdata_ff <= rd_mux;
    end
  end

  assign av_rsp.waitrequest = first_w;
  assign av_rsp.readdata    = rdata_ff;

  // ******************************************
  // checks
  // ******************************************
  sequence s_wr_set_ena0;
    wr_go && rw_hit[IBK_SL_ENA0] && op_w == IBK_OP_SET;
  endsequence
  sequence s_wr_clr_ctrl;
    wr_go && rw_hit[0] && op_w == IBK_OP_CLR && src_all == '0;
  endsequence
  sequence s_stat_alias;
    go_w && av_req.address[15:4] == IBK_OFF_STAT[15:4] &&
      av_req.address[3:2] != IBK_OP_BASE;
  endsequence

  property p_flag_set;
    @(posedge clk) disable iff (rst)
      (|src_all) |=> ((flags_w & $past(src_all)) == $past(src_all));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("source event did not set its flag");

  property p_req_gate;
    @(posedge clk) disable iff (rst)
      ##1 (cpu_req == |$past(pend_w));
  endproperty
  a_req_gate: assert property (p_req_gate)
    else $error("cpu request not equal to flag and enable");

  property p_set_alias;
    @(posedge clk) disable iff (rst)
      s_wr_set_ena0 |=>
        ((ena_w[31:0] & $past(wmask)) == $past(wmask));
  endproperty
  a_set_alias: assert property (p_set_alias)
    else $error("set alias did not set enable bits");

  property p_clr_alias;
    @(posedge clk) disable iff (rst)
      s_wr_clr_ctrl |=> ((regs_ff[0] & $past(wmask)) == 32'h0000_0000 &&
        (regs_ff[0] | $past(wmask)) == ($past(regs_ff[0]) | $past(wmask)));
  endproperty
  a_clr_alias: assert property (p_clr_alias)
    else $error("clear alias touched wrong bits");

  property p_stat_no_alias;
    @(posedge clk) disable iff (rst)
      s_stat_alias |=> evst_ff[IBK_EV_ERR];
  endproperty
  a_stat_no_alias: assert property (p_stat_no_alias)
    else $error("status alias was not treated as unmapped");

  property p_share;
    @(posedge clk) disable iff (rst)
      (|twowire3_src) |=>
        ((regs_ff[IBK_SL_FLG0][28:26] & $past(twowire3_src)) ==
          $past(twowire3_src));
  endproperty
  a_share: assert property (p_share)
    else $error("shared flag bit not set by twowire3 source");

  property p_vec_pending;
    @(posedge clk) disable iff (rst)
      cpu_req |-> pend_ff[best_idx_ff];
  endproperty
  a_vec_pending: assert property (p_vec_pending)
    else $error("reported vector was not pending");

  property p_one_wait;
    @(posedge clk) disable iff (rst)
      (req_w && av_rsp.waitrequest) |=> !av_rsp.waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("slave held waitrequest more than one cycle");

  sequence s_wr_inv_ena1;
    wr_go && rw_hit[IBK_SL_ENA0+1] && op_w == IBK_OP_INV;
  endsequence
  sequence s_wr_base_flg2;
    wr_go && rw_hit[IBK_SL_FLG0+2] && op_w == IBK_OP_BASE &&
      av_req.byteenable == 4'hf && src_all[95:64] == '0;
  endsequence

  property p_inv_alias;
    @(posedge clk) disable iff (rst)
      s_wr_inv_ena1 |=> (regs_ff[IBK_SL_ENA0+1] ==
        ($past(regs_ff[IBK_SL_ENA0+1]) ^ $past(wmask)));
  endproperty
  a_inv_alias: assert property (p_inv_alias)
    else $error("invert alias did not toggle enable bits");

  property p_base_flag;
    @(posedge clk) disable iff (rst)
      s_wr_base_flg2 |=> (flags_w[95:64] == $past(av_req.writedata));
  endproperty
  a_base_flag: assert property (p_base_flag)
    else $error("base write did not load flag word");

  property p_ena_block;
    @(posedge clk) disable iff (rst)
      (ena_w == '0) |=> !cpu_req;
  endproperty
  a_ena_block: assert property (p_ena_block)
    else $error("request raised with every source disabled");

  // set wins, so a clear in the same cycle cannot hide the event
  property p_pend_event;
    @(posedge clk) disable iff (rst)
      (|(pend_w & ~pend_ff)) |=> evst_ff[IBK_EV_PEND];
  endproperty
  a_pend_event: assert property (p_pend_event)
    else $error("new pending request did not set event bit");
endmodule : ibk_bank
`default_nettype wire

//--- rtl/ibk_pkg.sv
// constants and carrier types of the interrupt flag and enable bank
`default_nettype none
package ibk_pkg;
  // ******************************************
  // register offsets (byte addresses)
  // ******************************************
  localparam logic [15:0] IBK_OFF_CTRL = 16'h1000;
  localparam logic [15:0] IBK_OFF_STAT = 16'h1010;
  localparam logic [15:0] IBK_OFF_PTMR = 16'h1020;
  localparam logic [15:0] IBK_OFF_FLG0 = 16'h1030;
  localparam logic [15:0] IBK_OFF_FLG1 = 16'h1040;
  localparam logic [15:0] IBK_OFF_FLG2 = 16'h1050;
  localparam logic [15:0] IBK_OFF_ENA0 = 16'h1060;
  localparam logic [15:0] IBK_OFF_ENA1 = 16'h1070;
  localparam logic [15:0] IBK_OFF_ENA2 = 16'h1080;
  localparam logic [15:0] IBK_OFF_PRI0 = 16'h1090;
  localparam logic [15:0] IBK_OFF_EVST = 16'h10a0;
  localparam logic [15:0] IBK_OFF_EVMK = 16'h10b0;
  localparam int          IBK_NRW      = 9;
  localparam logic [15:0] IBK_RW_OFF [IBK_NRW] = '{
    IBK_OFF_CTRL, IBK_OFF_PTMR, IBK_OFF_FLG0, IBK_OFF_FLG1, IBK_OFF_FLG2,
    IBK_OFF_ENA0, IBK_OFF_ENA1, IBK_OFF_ENA2, IBK_OFF_PRI0};
  // slots of the storage array
  localparam int IBK_SL_FLG0 = 2;
  localparam int IBK_SL_ENA0 = 5;
  localparam int IBK_SL_PRI0 = 8;
  localparam logic [31:0] IBK_RST = 32'h0000_0000;
  // ******************************************
  // alias operations, selected by address bits 3:2
  // ******************************************
  localparam logic [1:0] IBK_OP_BASE = 2'h0;
  localparam logic [1:0] IBK_OP_CLR  = 2'h1;
  localparam logic [1:0] IBK_OP_SET  = 2'h2;
  localparam logic [1:0] IBK_OP_INV  = 2'h3;
  // ******************************************
  // field positions
  // ******************************************
  localparam int IBK_STAT_LVL_LSB = 8;
  localparam int IBK_STAT_VEC_LSB = 0;
  localparam int IBK_PRI_STRIDE   = 8;
  localparam int IBK_PRI_LVL_LSB  = 2;
  localparam int IBK_PRI_SUB_LSB  = 0;
  localparam int IBK_PRI_SLOTS    = 4;
  localparam int IBK_SHARE_LSB    = 26;
  localparam int IBK_EV_PEND      = 0;
  localparam int IBK_EV_ERR       = 1;
  localparam int IBK_NSRC         = 96;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ibk_av_req_t;
  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } ibk_av_rsp_t;
endpackage : ibk_pkg
`default_nettype wire

//--- bench/ibk_src_model.sv
// peripheral source model: pulses one interrupt line on command
`default_nettype none
module ibk_src_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        fire,
  input  wire logic [6:0]  num,
  output logic      [95:0] irq_src,
  output logic      [2:0]  serial1_src,
  output logic      [2:0]  spi3_src,
  output logic      [2:0]  twowire3_src
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // one-cycle pulses, 96 and up are shared
  // ****************************************
  logic [104:0] hot;
  assign hot = fire ? (105'h1 << num) : '0;
  always_ff @(posedge clk)
  begin
    irq_src      <= rst ? '0 : hot[95:0];
    serial1_src  <= rst ? '0 : hot[98:96];
    spi3_src     <= rst ? '0 : hot[101:99];
    twowire3_src <= rst ? '0 : hot[104:102];
  end
endmodule : ibk_src_model
`default_nettype wire

//--- bench/interrupt_flag_enable_bank_tb.sv
// self-checking bench of the interrupt flag and enable bank
`default_nettype none
module interrupt_flag_enable_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ibk_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  ibk_av_req_t av_req = '0;
  ibk_av_rsp_t av_rsp;
  logic        fire = 1'b0;
  logic [6:0]  num = '0;
  logic [95:0] irq_src;
  logic [2:0]  s1_src, s3_src, t3_src, cpu_level;
  logic        cpu_req, irq;
  logic [5:0]  cpu_vector;
  logic [31:0] rd;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] am [4] = '{32'h0f0f_0000, 32'h0300_0000, 32'h0000_00ff,
                          32'hffff_0000};
  logic [31:0] ae [4] = '{32'h0f0f_0000, 32'h0c0f_0000, 32'h0c0f_00ff,
                          32'hf3f0_00ff};
  always #5 clk = ~clk;
  ibk_bank #(.DEF_LVL(3'h1)) i_ibk_bank (
    .clk(clk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp),
    .irq_src(irq_src), .serial1_src(s1_src), .spi3_src(s3_src),
    .twowire3_src(t3_src), .cpu_req(cpu_req), .cpu_level(cpu_level),
    .cpu_vector(cpu_vector), .irq(irq));
  ibk_src_model i_ibk_src_model (
    .clk(clk), .rst(rst), .fire(fire), .num(num), .irq_src(irq_src),
    .serial1_src(s1_src), .spi3_src(s3_src), .twowire3_src(t3_src));
  // ****************************************
  // tasks
  // ****************************************
  task finish_test;
  begin
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask : finish_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
  begin
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  end
  endtask : chk
  // one wait state, but the master never counts on it
  task access(input logic w, input logic [15:0] a, input logic [31:0] d);
  begin
    av_req <= '{read: !w, write: w, address: a, writedata: d,
                byteenable: 4'hf};
    @(posedge clk);
    while (av_rsp.waitrequest !== 1'b0)
      @(posedge clk);
    rd = av_rsp.readdata;
    av_req <= '0;
    @(posedge clk);
  end
  endtask : access
  task rchk(input string nm, input logic [15:0] a, input logic [31:0] e);
  begin
    access(1'b0, a, 32'h0);
    chk(nm, e, rd);
  end
  endtask : rchk
  task pulse(input logic [6:0] n);
  begin
    fire <= 1'b1;
    num <= n;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  end
  endtask : pulse
  // ****************************************
  // sequence and timeout
  // ****************************************
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < IBK_NRW; i++)
      rchk("reset", IBK_RW_OFF[i], IBK_RST);
    rchk("status", IBK_OFF_STAT, IBK_RST);
    chk("irq", 32'h0, 32'(irq));
    for (int i = 0; i < 4; i++)
    begin
      access(1'b1, IBK_OFF_ENA1 + 16'(4 * i), am[i]);
      rchk("alias", IBK_OFF_ENA1 + 16'(4 * i), ae[i]);
    end
    access(1'b1, IBK_OFF_ENA1, 32'h0);
    access(1'b1, IBK_OFF_CTRL, 32'h1234_5678);
    access(1'b1, IBK_OFF_CTRL + 16'h4, 32'h0000_ff00);
    rchk("ctrl_clr", IBK_OFF_CTRL, 32'h1234_0078);
    access(1'b1, IBK_OFF_PTMR + 16'hc, 32'h8000_0001);
    rchk("ptmr_inv", IBK_OFF_PTMR + 16'h4, 32'h8000_0001);
    access(1'b1, IBK_OFF_STAT, 32'hffff_ffff);
    access(1'b1, IBK_OFF_STAT + 16'h8, 32'hffff_ffff);
    rchk("status", IBK_OFF_STAT, 32'h0);
    rchk("stat_alias", IBK_OFF_STAT + 16'h4, 32'h0);
    rchk("ev_unmapped", IBK_OFF_EVST, 32'h2);
    access(1'b1, IBK_OFF_EVST, 32'h2);
    rchk("ev_clear", IBK_OFF_EVST, 32'h0);
    pulse(7'd5);
    rchk("flag5", IBK_OFF_FLG0, 32'h20);
    access(1'b1, IBK_OFF_FLG0 + 16'h4, 32'h20);
    rchk("flag_clr", IBK_OFF_FLG0, 32'h0);
    pulse(7'd70);
    rchk("flag70", IBK_OFF_FLG2, 32'h40);
    access(1'b1, IBK_OFF_FLG2, 32'h8000_0000);
    rchk("flag_wr", IBK_OFF_FLG2, 32'h8000_0000);
    access(1'b1, IBK_OFF_FLG2, 32'h0);
    for (int k = 0; k < 9; k++)
    begin
      pulse(7'(96 + k));
      rchk("shared", IBK_OFF_FLG0, 32'h1 << (26 + k % 3));
      access(1'b1, IBK_OFF_FLG0 + 16'h4, 32'h1c00_0000);
    end
    pulse(7'd5);
    chk("req_blocked", 32'h0, 32'(cpu_req));
    access(1'b1, IBK_OFF_EVMK, 32'h1);
    access(1'b1, IBK_OFF_ENA0 + 16'h8, 32'h20);
    repeat (2) @(posedge clk);
    chk("req", 32'h1, 32'(cpu_req));
    chk("vector", 32'h5, 32'(cpu_vector));
    chk("level", 32'h1, 32'(cpu_level));
    chk("irq_set", 32'h1, 32'(irq));
    // level 5 in byte 2 must beat the default level
    access(1'b1, IBK_OFF_PRI0, 32'h0014_0000);
    pulse(7'd2);
    access(1'b1, IBK_OFF_ENA0 + 16'h8, 32'h4);
    repeat (2) @(posedge clk);
    chk("vector_pri", 32'h2, 32'(cpu_vector));
    chk("level_pri", 32'h5, 32'(cpu_level));
    access(1'b1, IBK_OFF_EVST, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clear", 32'h0, 32'(irq));
    access(1'b1, IBK_OFF_ENA0 + 16'h4, 32'h24);
    repeat (2) @(posedge clk);
    chk("req_off", 32'h0, 32'(cpu_req));
    finish_test;
  end
endmodule : interrupt_flag_enable_bank_tb
`default_nettype wire
